// [verilog/bbc_cfg.svh]
`ifndef BBC_CFG_SVH
`define BBC_CFG_SVH

`define BBC_RST_PC      16'h0000
`define BBC_RST_SP      8'hFF
`define BBC_DIR_PAGE    8'h00

`define BBC_GRP_BITBR   4'h0
`define BBC_GRP_BITSC   4'h1
`define BBC_GRP_REL     4'h2
`define BBC_GRP_RMW_DIR 4'h3
`define BBC_GRP_RMW_A   4'h4
`define BBC_GRP_RMW_X   4'h5
`define BBC_GRP_RMW_IX1 4'h6
`define BBC_GRP_RMW_IX  4'h7
`define BBC_GRP_CTL8    4'h8
`define BBC_GRP_CTL9    4'h9
`define BBC_GRP_IMM     4'hA
`define BBC_GRP_DIR     4'hB
`define BBC_GRP_EXT     4'hC
`define BBC_GRP_IX2     4'hD
`define BBC_GRP_IX1     4'hE
`define BBC_GRP_IX      4'hF

`define BBC_LO_SHR      4'h7
`define BBC_LO_SHL      4'h8
`define BBC_LO_AND      4'h4
`define BBC_LO_LDA      4'h6
`define BBC_LO_STA      4'h7
`define BBC_LO_EOR      4'h8
`define BBC_LO_ORA      4'hA
`define BBC_LO_ADD      4'hB
`define BBC_LO_JMP      4'hC
`define BBC_LO_JSR      4'hD
`define BBC_LO_LDX      4'hE
`define BBC_LO_STX      4'hF

`define BBC_OP_RTS      8'h81
`define BBC_OP_STOP     8'h8E
`define BBC_OP_WAIT     8'h8F
`define BBC_OP_TAX      8'h97
`define BBC_OP_CLC      8'h98
`define BBC_OP_SEC      8'h99
`define BBC_OP_CLI      8'h9A
`define BBC_OP_SEI      8'h9B
`define BBC_OP_RSP      8'h9C
`define BBC_OP_TXA      8'h9F

`define BBC_CYC_BIT     3'd5
`define BBC_CYC_REL     3'd3
`define BBC_CYC_INH     3'd2
`define BBC_CYC_RTS     3'd6
`define BBC_CYC_RMW_DIR 3'd5
`define BBC_CYC_RMW_INH 3'd3
`define BBC_CYC_RMW_IX1 3'd6
`define BBC_CYC_RMW_IX  3'd5
`define BBC_CYC_RM_IMM  3'd2
`define BBC_CYC_RM_DIR  3'd3
`define BBC_CYC_RM_EXT  3'd4
`define BBC_CYC_RM_IX2  3'd5
`define BBC_CYC_RM_IX1  3'd4
`define BBC_CYC_RM_IX   3'd3
`define BBC_CYC_JMP_DIR 3'd2
`define BBC_CYC_JMP_EXT 3'd3
`define BBC_CYC_JMP_IX2 3'd4
`define BBC_CYC_JMP_IX1 3'd3
`define BBC_CYC_JMP_IX  3'd2
`define BBC_CYC_JSR_DIR 3'd5
`define BBC_CYC_JSR_EXT 3'd6
`define BBC_CYC_JSR_IX2 3'd7
`define BBC_CYC_JSR_IX1 3'd6
`define BBC_CYC_JSR_IX  3'd5

`endif

// [verilog/bbc_pkg.sv]
package bbc_pkg;

	typedef enum logic [3:0] {
		S_FETCH = 4'b0000,
		S_OP1   = 4'b0001,
		S_OP2   = 4'b0010,
		S_READ  = 4'b0011,
		S_WRITE = 4'b0100,
		S_PUSHL = 4'b0101,
		S_PUSHH = 4'b0110,
		S_POPH  = 4'b0111,
		S_POPL  = 4'b1000,
		S_EXEC  = 4'b1001,
		S_PAD   = 4'b1010,
		S_HALT  = 4'b1011
	} bbc_state_e;

	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic c;
	} bbc_ccr_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} bbc_bus_s;

endpackage

// [verilog/bbc_branch_cond.sv]
module bbc_branch_cond
	import bbc_pkg::*;
(
	input  wire logic [3:0] cond,
	input  bbc_ccr_s        flags,
	input  wire logic       irq_pin_n,
	output logic            take
);

	always_comb begin
		case (cond)
			4'h0: take = 1'b1;
			4'h1: take = 1'b0;
			4'h2: take = !(flags.c | flags.z);
			4'h3: take = flags.c | flags.z;
			4'h4: take = !flags.c;
			4'h5: take = flags.c;
			4'h6: take = !flags.z;
			4'h7: take = flags.z;
			4'h8: take = !flags.h;
			4'h9: take = flags.h;
			4'hA: take = !flags.n;
			4'hB: take = flags.n;
			4'hC: take = !flags.i;
			4'hD: take = flags.i;
			4'hE: take = !irq_pin_n;
			4'hF: take = irq_pin_n;
			default: take = 1'b0;
		endcase
	end

endmodule // bbc_branch_cond

// [verilog/bbc_shift_unit.sv]
module bbc_shift_unit (
	input  wire logic       shift_left,
	input  wire logic [7:0] din,
	output logic [7:0]      dout,
	output logic            neg,
	output logic            zero,
	output logic            carry
);

	always_comb begin
		if (shift_left) begin
			dout  = {din[6:0], 1'b0};
			carry = din[7];
		end else begin
			dout  = {din[7], din[7:1]};
			carry = din[0];
		end
		neg  = dout[7];
		zero = (dout == 8'h00);
	end

endmodule // bbc_shift_unit

// [verilog/bbc_core.sv]
// Overview of operation
// - Branch-if-bit-clear/set are three bytes, testing any bit in lowest 256 addresses.
// - Second byte is the tested byte's direct address; third is signed displacement.
// - Bit position and sense come from opcode; displacement added only on success.
// - Targets relative to next instruction, two's complement range -128 to +127.
// - Tested memory bit is copied into carry whether or not branch is taken.
// - Failed branch leaves program counter sequence; next instruction follows.
// - Set or clear any writable bit within lowest 256 memory bytes.
// - Bit clear is direct only, opcodes 11 upward by two, five cycles, flags kept.
// - Opcode 24 branches on carry clear, PC plus 2 plus offset, three cycles.
// - Higher-or-same shares opcode 24; opcode 22 needs carry and zero both clear.
// - Opcode 25 branches on carry set, opcode 27 on zero set.
// - Opcodes 28 and 29 branch on half-carry clear and set, flags untouched.
// - Branches on interrupt mask clear and on mask set.
// - Shift left 38..78, shift right 37..77; 5,3,3,6,5 cycles; set N Z C.
// - Stop halts oscillator and enables the external interrupt pin to resume.
// - Wait stops CPU clock, enables interrupts; an interrupt resumes execution.
// - Copy accumulator to index register and index register to accumulator.
// - Jump and jump-to-subroutine take only an address and load the PC with it.
// - Direct addressing forces operand address high byte to zero.
// - Branch-if-bit-clear bit 0 is opcode 01, then odd opcodes, five cycles each.
`include "bbc_cfg.svh"

module bbc_core
	import bbc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	output bbc_bus_s        mem_bus,
	input  wire logic [7:0] mem_rdata,
	input  wire logic       irq_pin_n,
	input  wire logic       int_req,
	output bbc_ccr_s        condition_code_register,
	output logic [7:0]      acc,
	output logic [7:0]      idx,
	output logic [15:0]     pc,
	output logic            osc_stop,
	output logic            cpu_clk_stop,
	output logic            instr_start
);

	bbc_state_e  state_r;
	bbc_state_e  state_nxt;
	bbc_state_e  end_st;
	bbc_state_e  acc_st;
	bbc_ccr_s    ccr_r;
	logic [2:0]  cnt_r;
	logic [2:0]  total_r;
	logic [15:0] pc_r;
	logic [15:0] ea_r;
	logic [15:0] ea_calc;
	logic [15:0] rel_target;
	logic [15:0] bit_target;
	logic [7:0]  op_r;
	logic [7:0]  tmp_r;
	logic [7:0]  wdata_r;
	logic [7:0]  sp_r;
	logic [7:0]  a_r;
	logic [7:0]  x_r;
	logic [7:0]  alu_res;
	logic [7:0]  sh_in;
	logic [7:0]  sh_out;
	logic [8:0]  add_sum;
	logic [3:0]  hi;
	logic [3:0]  lo;
	logic        is_rmw;
	logic        is_reg;
	logic        is_st;
	logic        rmw_shift;
	logic        take_rel;
	logic        tested_bit;
	logic        sh_n;
	logic        sh_z;
	logic        sh_c;
	logic        fin;
	logic        wake;
	logic        stop_r;
	logic        halt_r;
	logic        alu_go;

	assign hi         = op_r[7:4];
	assign lo         = op_r[3:0];
	assign is_rmw     = (hi >= `BBC_GRP_RMW_DIR) && (hi <= `BBC_GRP_RMW_IX);
	assign is_reg     = (hi >= `BBC_GRP_IMM);
	assign is_st      = (lo == `BBC_LO_STA) || (lo == `BBC_LO_STX);
	assign rmw_shift  = (lo == `BBC_LO_SHL) || (lo == `BBC_LO_SHR);
	assign tested_bit = mem_rdata[op_r[3:1]];
	assign rel_target = pc_r + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
	assign bit_target = pc_r + {{8{tmp_r[7]}}, tmp_r};
	assign fin        = ({1'b0, cnt_r} + 4'h1) >= {1'b0, total_r};
	assign end_st     = fin ? S_FETCH : S_PAD;
	assign wake       = stop_r ? !irq_pin_n : (!irq_pin_n || int_req);
	assign alu_go     = ((state_r == S_OP1) && (hi == `BBC_GRP_IMM)) || ((state_r == S_READ) && is_reg);
	assign sh_in      = (state_r == S_READ) ? mem_rdata : ((hi == `BBC_GRP_RMW_A) ? a_r : x_r);
	assign add_sum    = {1'b0, a_r} + {1'b0, mem_rdata};

	bbc_branch_cond u_cond (
		.cond      (lo),
		.flags     (ccr_r),
		.irq_pin_n (irq_pin_n),
		.take      (take_rel)
	);

	bbc_shift_unit u_shift (
		.shift_left (lo == `BBC_LO_SHL),
		.din        (sh_in),
		.dout       (sh_out),
		.neg        (sh_n),
		.zero       (sh_z),
		.carry      (sh_c)
	);

	function automatic logic needs_op(input logic [7:0] opc);
		case (opc[7:4])
			`BBC_GRP_BITBR, `BBC_GRP_BITSC, `BBC_GRP_REL: needs_op = 1'b1;
			`BBC_GRP_RMW_DIR, `BBC_GRP_RMW_IX1: needs_op = 1'b1;
			`BBC_GRP_IMM, `BBC_GRP_DIR, `BBC_GRP_EXT, `BBC_GRP_IX2, `BBC_GRP_IX1: needs_op = 1'b1;
			default: needs_op = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] cyc_of(input logic [7:0] opc);
		logic [3:0] l;
		l = opc[3:0];
		case (opc[7:4])
			`BBC_GRP_BITBR, `BBC_GRP_BITSC: cyc_of = `BBC_CYC_BIT;
			`BBC_GRP_REL: cyc_of = `BBC_CYC_REL;
			`BBC_GRP_RMW_DIR: cyc_of = `BBC_CYC_RMW_DIR;
			`BBC_GRP_RMW_A, `BBC_GRP_RMW_X: cyc_of = `BBC_CYC_RMW_INH;
			`BBC_GRP_RMW_IX1: cyc_of = `BBC_CYC_RMW_IX1;
			`BBC_GRP_RMW_IX: cyc_of = `BBC_CYC_RMW_IX;
			`BBC_GRP_CTL8: cyc_of = (opc == `BBC_OP_RTS) ? `BBC_CYC_RTS : `BBC_CYC_INH;
			`BBC_GRP_CTL9, `BBC_GRP_IMM: cyc_of = `BBC_CYC_RM_IMM;
			`BBC_GRP_DIR: cyc_of = (l == `BBC_LO_JMP) ? `BBC_CYC_JMP_DIR :
				(l == `BBC_LO_JSR) ? `BBC_CYC_JSR_DIR : `BBC_CYC_RM_DIR;
			`BBC_GRP_EXT: cyc_of = (l == `BBC_LO_JMP) ? `BBC_CYC_JMP_EXT :
				(l == `BBC_LO_JSR) ? `BBC_CYC_JSR_EXT : `BBC_CYC_RM_EXT;
			`BBC_GRP_IX2: cyc_of = (l == `BBC_LO_JMP) ? `BBC_CYC_JMP_IX2 :
				(l == `BBC_LO_JSR) ? `BBC_CYC_JSR_IX2 : `BBC_CYC_RM_IX2;
			`BBC_GRP_IX1: cyc_of = (l == `BBC_LO_JMP) ? `BBC_CYC_JMP_IX1 :
				(l == `BBC_LO_JSR) ? `BBC_CYC_JSR_IX1 : `BBC_CYC_RM_IX1;
			default: cyc_of = (l == `BBC_LO_JMP) ? `BBC_CYC_JMP_IX :
				(l == `BBC_LO_JSR) ? `BBC_CYC_JSR_IX : `BBC_CYC_RM_IX;
		endcase
	endfunction

	// Effective address; direct page forced to zero
	always_comb begin
		case (state_r)
			S_OP1: begin
				if ((hi == `BBC_GRP_RMW_IX1) || (hi == `BBC_GRP_IX1))
					ea_calc = {7'h00, {1'b0, mem_rdata} + {1'b0, x_r}};
				else
					ea_calc = {`BBC_DIR_PAGE, mem_rdata};
			end
			S_OP2: begin
				// Bit branch keeps the tested byte's address; its third byte is only the offset
				if (hi == `BBC_GRP_BITBR)
					ea_calc = ea_r;
				else
					ea_calc = {tmp_r, mem_rdata} + ((hi == `BBC_GRP_IX2) ? {8'h00, x_r} : 16'h0000);
			end
			default: ea_calc = {`BBC_DIR_PAGE, x_r};
		endcase
	end

	always_comb begin
		if (lo == `BBC_LO_JMP)
			acc_st = end_st;
		else if (lo == `BBC_LO_JSR)
			acc_st = S_PUSHL;
		else if (is_st)
			acc_st = S_WRITE;
		else
			acc_st = S_READ;
	end

	always_comb begin
		case (lo)
			`BBC_LO_AND: alu_res = a_r & mem_rdata;
			`BBC_LO_EOR: alu_res = a_r ^ mem_rdata;
			`BBC_LO_ORA: alu_res = a_r | mem_rdata;
			`BBC_LO_ADD: alu_res = add_sum[7:0];
			default:     alu_res = mem_rdata;
		endcase
	end

	always_comb begin
		case (state_r)
			S_FETCH: state_nxt = needs_op(mem_rdata) ? S_OP1 : S_EXEC;
			S_OP1: begin
				case (hi)
					`BBC_GRP_BITBR: state_nxt = S_OP2;
					`BBC_GRP_BITSC: state_nxt = S_READ;
					`BBC_GRP_RMW_DIR, `BBC_GRP_RMW_IX1: state_nxt = rmw_shift ? S_READ : end_st;
					`BBC_GRP_EXT, `BBC_GRP_IX2: state_nxt = S_OP2;
					`BBC_GRP_DIR, `BBC_GRP_IX1: state_nxt = acc_st;
					default: state_nxt = end_st;
				endcase
			end
			S_OP2: state_nxt = (hi == `BBC_GRP_BITBR) ? S_READ : acc_st;
			S_READ: state_nxt = ((hi == `BBC_GRP_BITSC) || is_rmw) ? S_WRITE : end_st;
			S_WRITE, S_PUSHH, S_POPL, S_PAD: state_nxt = end_st;
			S_PUSHL: state_nxt = S_PUSHH;
			S_POPH: state_nxt = S_POPL;
			S_EXEC: begin
				if (hi == `BBC_GRP_RMW_IX)
					state_nxt = rmw_shift ? S_READ : end_st;
				else if (hi == `BBC_GRP_IX)
					state_nxt = acc_st;
				else if (op_r == `BBC_OP_RTS)
					state_nxt = S_POPH;
				else if ((op_r == `BBC_OP_STOP) || (op_r == `BBC_OP_WAIT))
					state_nxt = S_HALT;
				else
					state_nxt = end_st;
			end
			S_HALT: state_nxt = wake ? S_FETCH : S_HALT;
			default: state_nxt = S_FETCH;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= S_FETCH;
			cnt_r   <= 3'd0;
			total_r <= 3'd1;
		end else begin
			state_r <= state_nxt;
			if (state_r == S_FETCH) begin
				cnt_r   <= 3'd1;
				total_r <= cyc_of(mem_rdata);
			end else if (state_r != S_HALT) begin
				cnt_r <= cnt_r + 3'd1;
			end
		end
	end

	// Halt flags stay up until the wake condition
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stop_r <= 1'b0;
			halt_r <= 1'b0;
		end else if ((state_r == S_EXEC) && (state_nxt == S_HALT)) begin
			stop_r <= (op_r == `BBC_OP_STOP);
			halt_r <= 1'b1;
		end else if ((state_r == S_HALT) && wake) begin
			stop_r <= 1'b0;
			halt_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pc_r    <= `BBC_RST_PC;
			ea_r    <= 16'h0000;
			op_r    <= 8'h00;
			tmp_r   <= 8'h00;
			wdata_r <= 8'h00;
			sp_r    <= `BBC_RST_SP;
		end else begin
			case (state_r)
				S_FETCH: begin
					op_r <= mem_rdata;
					pc_r <= pc_r + 16'h0001;
				end
				S_OP1, S_OP2: begin
					tmp_r <= mem_rdata;
					ea_r  <= ea_calc;
					if ((hi == `BBC_GRP_REL) && (state_r == S_OP1) && take_rel)
						pc_r <= rel_target;
					else if (is_reg && (lo == `BBC_LO_JMP) && (state_nxt != S_OP2) && (hi != `BBC_GRP_IMM))
						pc_r <= ea_calc;
					else
						pc_r <= pc_r + 16'h0001;
					if (is_st)
						wdata_r <= (lo == `BBC_LO_STA) ? a_r : x_r;
				end
				S_READ: begin
					if ((hi == `BBC_GRP_BITBR) && (tested_bit ^ op_r[0]))
						pc_r <= bit_target;
					if (hi == `BBC_GRP_BITSC) begin
						wdata_r           <= mem_rdata;
						wdata_r[op_r[3:1]] <= !op_r[0];
					end else begin
						wdata_r <= sh_out;
					end
				end
				S_EXEC: begin
					ea_r <= ea_calc;
					if ((hi == `BBC_GRP_IX) && (lo == `BBC_LO_JMP))
						pc_r <= ea_calc;
					if (is_st)
						wdata_r <= (lo == `BBC_LO_STA) ? a_r : x_r;
					if (op_r == `BBC_OP_RSP)
						sp_r <= `BBC_RST_SP;
				end
				S_PUSHL: sp_r <= sp_r - 8'h01;
				S_PUSHH: begin
					sp_r <= sp_r - 8'h01;
					pc_r <= ea_r;
				end
				S_POPH: begin
					sp_r       <= sp_r + 8'h01;
					pc_r[15:8] <= mem_rdata;
				end
				S_POPL: begin
					sp_r      <= sp_r + 8'h01;
					pc_r[7:0] <= mem_rdata;
				end
				default: pc_r <= pc_r;
			endcase
		end
	end

	// Accumulator, index and condition codes
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			a_r   <= 8'h00;
			x_r   <= 8'h00;
			ccr_r <= '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
		end else if ((state_r == S_READ) && (hi == `BBC_GRP_BITBR)) begin
			ccr_r.c <= tested_bit;
		end else if (((state_r == S_READ) && is_rmw) ||
				((state_r == S_EXEC) && ((hi == `BBC_GRP_RMW_A) || (hi == `BBC_GRP_RMW_X)) && rmw_shift)) begin
			ccr_r.n <= sh_n;
			ccr_r.z <= sh_z;
			ccr_r.c <= sh_c;
			if (state_r == S_EXEC) begin
				if (hi == `BBC_GRP_RMW_A)
					a_r <= sh_out;
				else
					x_r <= sh_out;
			end
		end else if (alu_go && !is_st && (lo != `BBC_LO_JMP) && (lo != `BBC_LO_JSR)) begin
			ccr_r.n <= alu_res[7];
			ccr_r.z <= (alu_res == 8'h00);
			if (lo == `BBC_LO_LDX)
				x_r <= alu_res;
			else
				a_r <= alu_res;
			if (lo == `BBC_LO_ADD) begin
				ccr_r.c <= add_sum[8];
				ccr_r.h <= add_sum[4] ^ a_r[4] ^ mem_rdata[4];
			end
		end else if (state_r == S_EXEC) begin
			case (op_r)
				`BBC_OP_TAX: x_r <= a_r;
				`BBC_OP_TXA: a_r <= x_r;
				`BBC_OP_CLC: ccr_r.c <= 1'b0;
				`BBC_OP_SEC: ccr_r.c <= 1'b1;
				`BBC_OP_SEI: ccr_r.i <= 1'b1;
				`BBC_OP_CLI, `BBC_OP_STOP, `BBC_OP_WAIT: ccr_r.i <= 1'b0;
				default: ccr_r.i <= ccr_r.i;
			endcase
		end
	end

	always_comb begin
		mem_bus = '{addr: pc_r, wdata: wdata_r, rd: 1'b0, wr: 1'b0};
		case (state_r)
			S_FETCH, S_OP1, S_OP2: mem_bus.rd = 1'b1;
			S_READ: begin
				mem_bus.addr = ea_r;
				mem_bus.rd   = 1'b1;
			end
			S_WRITE: begin
				mem_bus.addr = ea_r;
				mem_bus.wr   = 1'b1;
			end
			S_PUSHL, S_PUSHH: begin
				mem_bus.addr  = {`BBC_DIR_PAGE, sp_r};
				mem_bus.wdata = (state_r == S_PUSHL) ? pc_r[7:0] : pc_r[15:8];
				mem_bus.wr    = 1'b1;
			end
			S_POPH, S_POPL: begin
				mem_bus.addr = {`BBC_DIR_PAGE, sp_r + 8'h01};
				mem_bus.rd   = 1'b1;
			end
			default: mem_bus.rd = 1'b0;
		endcase
	end

	assign condition_code_register          = ccr_r;
	assign acc          = a_r;
	assign idx          = x_r;
	assign pc           = pc_r;
	assign osc_stop     = stop_r;
	assign cpu_clk_stop = halt_r;
	assign instr_start  = (state_r == S_FETCH);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_fetch(logic [3:0] grp);
		(state_r == S_FETCH) && (mem_rdata[7:4] == grp);
	endsequence
	sequence s_busy4;
		(state_r != S_FETCH) [*4];
	endsequence

	rel_timing_a: assert property (s_fetch(4'h2) |=> (state_r != S_FETCH) ##1 (state_r != S_FETCH) ##1 (state_r == S_FETCH)) else $error("relative branch not 3 cycles");
	bitsc_timing_a: assert property (s_fetch(4'h1) |=> s_busy4 ##1 (state_r == S_FETCH)) else $error("bit set/clear not 5 cycles");
	bitbr_timing_a: assert property (s_fetch(4'h0) |=> s_busy4 ##1 (state_r == S_FETCH)) else $error("bit branch not 5 cycles");
	shl_timing_a: assert property (s_fetch(4'h3) ##0 (mem_rdata[3:0] == 4'h8) |=> s_busy4 ##1 (state_r == S_FETCH)) else $error("direct shift not 5 cycles");
	dir_page_a: assert property ((state_r == S_READ || state_r == S_WRITE) && (hi <= 4'h1) |-> mem_bus.addr[15:8] == 8'h00) else $error("direct high byte not zero");
	bit_carry_a: assert property ((state_r == S_READ) && (hi == 4'h0) |=> ccr_r.c == $past(tested_bit)) else $error("tested bit not in carry");
	rel_skip_a: assert property ((state_r == S_OP1) && (hi == 4'h2) && !take_rel |=> pc_r == $past(pc_r) + 16'h0001) else $error("untaken branch moved pc");
	rel_take_a: assert property ((state_r == S_OP1) && (hi == 4'h2) && take_rel |=> pc_r == $past(rel_target)) else $error("taken branch target wrong");
	rel_flags_a: assert property ((state_r == S_OP1) && (hi == 4'h2) |=> $stable(ccr_r)) else $error("branch changed flags");
	bit_write_a: assert property ((state_r == S_WRITE) && (hi == 4'h1) |-> mem_bus.wdata[op_r[3:1]] == !op_r[0]) else $error("bit write value wrong");
	stop_halt_a: assert property ((state_r == S_EXEC) && (op_r == 8'h8E) |=> osc_stop && cpu_clk_stop && !ccr_r.i) else $error("stop did not halt");
	tax_copy_a: assert property ((state_r == S_EXEC) && (op_r == 8'h97) |=> x_r == $past(a_r)) else $error("copy to index wrong");

endmodule // bbc_core

// [verif/bbc_mem_model.sv]
module bbc_mem_model
	import bbc_pkg::*;
(
	input  wire logic  core_clk,
	input  bbc_bus_s   mem_bus,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] mem [0:1023];
	logic [7:0] last_r;

	initial last_r = 8'h00;

	// Idle bus shows the inverted last read, so a stale byte never passes
	assign mem_rdata = mem_bus.rd ? mem[mem_bus.addr[9:0]] : ~last_r;

	// Plain always: the bench also loads this array directly
	always @(posedge core_clk) begin
		if (mem_bus.rd) last_r <= mem[mem_bus.addr[9:0]];
		if (mem_bus.wr) mem[mem_bus.addr[9:0]] <= mem_bus.wdata;
	end
endmodule // bbc_mem_model

// [verif/tb_top.sv]
module tb_top
	import bbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk;
	logic        nrst;
	logic        irq_pin_n;
	logic        int_req;
	bbc_bus_s    mem_bus;
	logic [7:0]  mem_rdata;
	bbc_ccr_s    condition_code_register;
	logic [7:0]  acc;
	logic [7:0]  idx;
	logic [15:0] pc;
	logic        osc_stop;
	logic        cpu_clk_stop;
	logic        instr_start;
	logic [15:0] wp;
	int          num_errors;
	int          n_checks;

	bbc_core DUT (.core_clk(core_clk), .nrst(nrst), .mem_bus(mem_bus), .mem_rdata(mem_rdata),
		.irq_pin_n(irq_pin_n), .int_req(int_req), .condition_code_register(condition_code_register), .acc(acc), .idx(idx), .pc(pc),
		.osc_stop(osc_stop), .cpu_clk_stop(cpu_clk_stop), .instr_start(instr_start));
	bbc_mem_model mem_i (.core_clk(core_clk), .mem_bus(mem_bus), .mem_rdata(mem_rdata));

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// Memory is reloaded only while the core sits in reset
	task automatic hold_rst;
		@(posedge core_clk);
		#1 nrst = 1'b0;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < 1024; i++) mem_i.mem[i] = 8'h9D;
		wp = 16'h0000;
	endtask
	task automatic go;
		#1 nrst = 1'b1;
	endtask
	task automatic put(input logic [7:0] b);
		mem_i.mem[wp[9:0]] = b;
		wp++;
	endtask
	task automatic step(output int cyc);
		cyc = 0;
		do begin
			@(posedge core_clk);
			#1 cyc++;
		end while (instr_start !== 1'b1 && cyc < 40);
	endtask
	task automatic run(input int k);
		int c;
		repeat (k) step(c);
	endtask

	task automatic t_bit_branch;
		logic [7:0] op, rr, d;
		logic [15:0] tgt;
		int c;
		d = 8'hA5;
		for (int i = 0; i < 16; i++) begin
			op = i[7:0];
			rr = op[1] ? 8'hF0 : 8'h10;
			tgt = (d[op[3:1]] == !op[0]) ? 16'h0003 + {{8{rr[7]}}, rr} : 16'h0003;
			hold_rst;
			put(op); put(8'h40); put(rr);
			mem_i.mem[10'h040] = d;
			mem_i.mem[10'h140] = ~d;
			go;
			step(c);
			chk(c == 5, "bit branch cycle count");
			chk(pc === tgt, "bit branch target");
			chk(condition_code_register.c === d[op[3:1]], "tested bit not in carry");
		end
	endtask

	task automatic t_bit_setclr;
		logic [7:0] op, ex;
		int c;
		for (int i = 0; i < 16; i++) begin
			op = 8'h10 | i[7:0];
			ex = 8'h5A;
			ex[op[3:1]] = !op[0];
			hold_rst;
			put(op); put(8'h41);
			mem_i.mem[10'h041] = 8'h5A;
			go;
			step(c);
			chk(c == 5, "bit set/clear cycle count");
			chk(mem_i.mem[10'h041] === ex && mem_i.mem[10'h141] === 8'h9D, "bit set/clear result");
			chk(condition_code_register === 5'h08, "bit set/clear touched flags");
		end
	endtask

	task automatic t_rel_branch;
		logic [7:0] ops [16] = '{8'h24, 8'h24, 8'h22, 8'h22, 8'h22, 8'h25, 8'h25, 8'h27,
			8'h27, 8'h28, 8'h28, 8'h29, 8'h29, 8'h2C, 8'h2C, 8'h2D};
		int pf [16] = '{0, 1, 0, 1, 2, 1, 0, 2, 0, 0, 3, 3, 0, 0, 4, 0};
		logic [15:0] tk, base;
		bbc_ccr_s sv;
		int c;
		tk = 16'hCAA5;
		for (int i = 0; i < 16; i++) begin
			hold_rst;
			case (pf[i])
				1: put(8'h99);
				2: begin put(8'hA6); put(8'h00); end
				3: begin put(8'hA6); put(8'h0F); put(8'hAB); put(8'h01); end
				4: put(8'h9A);
				default: ;
			endcase
			base = wp;
			put(ops[i]); put(8'h10);
			go;
			run(pf[i] == 3 ? 2 : (pf[i] == 0 ? 0 : 1));
			sv = condition_code_register;
			step(c);
			chk(c == 3, "relative branch cycle count");
			chk(pc === base + 16'h0002 + (tk[i] ? 16'h0010 : 16'h0000), "relative branch pc");
			chk(condition_code_register === sv, "relative branch changed flags");
		end
	endtask

	task automatic t_shift;
		logic [7:0] ops [10] = '{8'h38, 8'h48, 8'h58, 8'h68, 8'h78, 8'h37, 8'h47, 8'h57, 8'h67, 8'h77};
		int cy [5] = '{5, 3, 3, 6, 5};
		logic [7:0] op, v, ex, got;
		logic ec;
		int c;
		for (int i = 0; i < 10; i++) begin
			op = ops[i];
			hold_rst;
			put(8'hA6); put(8'h81); put(8'hAE); put(8'h42); put(op);
			if (op[7:4] == 4'h3) put(8'h42);
			if (op[7:4] == 4'h6) put(8'h00);
			mem_i.mem[10'h042] = 8'h81;
			go;
			run(2);
			step(c);
			v = (op[7:4] == 4'h5) ? 8'h42 : 8'h81;
			ex = op[3] ? {v[6:0], 1'b0} : {v[7], v[7:1]};
			ec = op[3] ? v[7] : v[0];
			got = (op[7:4] == 4'h4) ? acc : ((op[7:4] == 4'h5) ? idx : mem_i.mem[10'h042]);
			chk(c == cy[i % 5], "shift cycle count");
			chk(got === ex, "shift result");
			chk(condition_code_register.c === ec && condition_code_register.z === (ex == 8'h00) && condition_code_register.n === ex[7], "shift flags");
		end
	endtask

	task automatic t_ctl_jump;
		int c;
		hold_rst;
		put(8'hA6); put(8'h3C); put(8'h97); put(8'hAE); put(8'h11); put(8'h9F);
		put(8'hCD); put(8'h01); put(8'h23);
		wp = 16'h0123;
		put(8'hBC); put(8'h50);
		go;
		run(2);
		chk(idx === 8'h3C, "accumulator to index");
		run(2);
		chk(acc === 8'h11, "index to accumulator");
		step(c);
		chk(c == 6 && pc === 16'h0123, "subroutine jump");
		chk(mem_i.mem[10'h0FF] === 8'h09 && mem_i.mem[10'h0FE] === 8'h00, "return address push");
		step(c);
		chk(c == 2 && pc === 16'h0050, "direct jump");
	endtask

	// One load per addressing mode, index held at 44
	task automatic t_reg_mem;
		logic [7:0] ev [6] = '{8'h55, 8'h11, 8'h22, 8'h33, 8'h44, 8'h33};
		int cy [6] = '{2, 3, 4, 5, 4, 3};
		int c;
		hold_rst;
		put(8'hAE); put(8'h44); put(8'hA6); put(8'h55); put(8'hB6); put(8'h40);
		put(8'hC6); put(8'h00); put(8'h41); put(8'hD6); put(8'h00); put(8'h00);
		put(8'hE6); put(8'h01); put(8'hF6);
		mem_i.mem[10'h040] = 8'h11;
		mem_i.mem[10'h041] = 8'h22;
		mem_i.mem[10'h044] = 8'h33;
		mem_i.mem[10'h045] = 8'h44;
		go;
		run(1);
		for (int i = 0; i < 6; i++) begin
			step(c);
			chk(c == cy[i] && acc === ev[i], "register/memory mode cycles or data");
		end
	endtask

	task automatic t_stop_wait;
		int c;
		hold_rst;
		put(8'h8E); put(8'h8F);
		go;
		repeat (4) @(posedge core_clk);
		#1 chk(osc_stop === 1'b1 && cpu_clk_stop === 1'b1 && condition_code_register.i === 1'b0, "stop entry");
		int_req = 1'b1;
		repeat (10) @(posedge core_clk);
		#1 chk(osc_stop === 1'b1 && instr_start === 1'b0, "stop woke on internal request");
		irq_pin_n = 1'b0;
		step(c);
		chk(c < 4 && pc === 16'h0001 && osc_stop === 1'b0, "stop wake by pin");
		irq_pin_n = 1'b1;
		int_req = 1'b0;
		repeat (4) @(posedge core_clk);
		#1 chk(cpu_clk_stop === 1'b1 && osc_stop === 1'b0 && condition_code_register.i === 1'b0, "wait entry");
		int_req = 1'b1;
		step(c);
		chk(c < 4 && pc === 16'h0002 && cpu_clk_stop === 1'b0, "wait wake by request");
		int_req = 1'b0;
	endtask

	task automatic wrap_up;
		$display("checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run needs well under 5000 cycles
	initial begin
		#100000;
		num_errors++;
		wrap_up;
	end

	initial begin
		nrst = 1'b0;
		irq_pin_n = 1'b1;
		int_req = 1'b0;
		wp = 16'h0000;
		num_errors = 0;
		n_checks = 0;
		t_bit_branch;
		t_bit_setclr;
		t_rel_branch;
		t_shift;
		t_ctl_jump;
		t_reg_mem;
		t_stop_wait;
		wrap_up;
	end
endmodule // tb_top
